// [darb_pkg.sv]
// darb_pkg: register map, field positions, reset values and timing
// assumes one 250 MHz clock and a plain address/strobe register port
package darb_pkg;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_LIMIT_FAIL_FLAGS = 8'h23;
  localparam logic [7:0] OFS_INPUT_ZERO_RESULT = 8'h24;
  localparam logic [7:0] OFS_INPUT_ONE_RESULT = 8'h25;
  localparam logic [7:0] OFS_DIE_TEMP_RESULT = 8'h26;
  localparam logic [7:0] OFS_SELF_CHECK_MUX_RESULT = 8'h27;
  localparam logic [7:0] OFS_COMPARATOR_OFFSET = 8'h28;
  localparam logic [7:0] OFS_APPLIED_OUTPUT_CODE = 8'h2C;
  localparam logic [7:0] OFS_RAW_CONVERSION_DATA = 8'h2D;
  localparam logic [7:0] OFS_CONVERSION_OVERRIDE = 8'h2E;
  localparam logic [7:0] OFS_EVENT_STATUS = 8'h30;
  localparam logic [7:0] OFS_EVENT_MASK = 8'h31;
  // ----------------------------------------------------------------
  // field positions and widths
  // ----------------------------------------------------------------
  localparam int DATA_W = 12;
  localparam int REG_W = 16;
  localparam int NUM_CHAN = 8;
  localparam int BIT_DATA_SUBSTITUTE_ON = 15;
  localparam int BIT_OFFSET_OVERRIDE_ON = 14;
  localparam int BIT_GROUND_SAMPLE_OFF = 13;
  localparam int FLAG_FIRST_BIT = 1;
  localparam int EVT_W = 2;
  localparam int EVT_CONV_DONE = 0;
  localparam int EVT_LIMIT_FAIL = 1;
  // ----------------------------------------------------------------
  // channel codes; a channel's flag bit is its code plus one
  // ----------------------------------------------------------------
  localparam logic [2:0] CH_INPUT_ZERO = 3'h0;
  localparam logic [2:0] CH_INPUT_ONE = 3'h1;
  localparam logic [2:0] CH_DIE_TEMP = 3'h2;
  localparam logic [2:0] CH_SELF_CHECK_FIRST = 3'h3;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_REG = 16'h0000;
  localparam logic [11:0] RST_DATA = 12'h000;
  localparam logic [1:0] RST_EVT = 2'h0;
  localparam logic [11:0] DATA_MAX = 12'hFFF;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 4000;
  localparam int GND_SAMPLE_NS = 40;
  localparam int GND_SAMPLE_CYC = (GND_SAMPLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // sequencer states
  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b001,
    SEQ_GND = 3'b010,
    SEQ_CONV = 3'b100
  } darb_seq_t;
endpackage

// [darb_top.sv]
// darb_top: result, offset and bypass logic of the diagnostic converter
// assumes the converter core delivers raw codes with a one-cycle strobe,
// and the threshold window of the channel arrives beside each request
//
// The address-and-strobe port was chosen for this implementation.
module darb_top (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic [7:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [15:0] RDATA,
  input wire logic CHAN_REQ,
  input wire logic [2:0] CHAN_SEL,
  input wire logic [11:0] LIMIT_LO,
  input wire logic [11:0] LIMIT_HI,
  output logic REQ_READY,
  output logic GND_SAMPLE,
  output logic SAR_START,
  output logic [2:0] SAR_CHAN,
  input wire logic SAR_DONE,
  input wire logic [11:0] SAR_RAW,
  input wire logic OFS_VALID,
  input wire logic [11:0] OFS_MEAS,
  input wire logic [15:0] DAC_CODE,
  output logic IRQ
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  darb_pkg::darb_seq_t seq_q;
  logic [7:0] gnd_cnt_q;
  logic [2:0] chan_q;
  logic [11:0] lim_lo_q;
  logic [11:0] lim_hi_q;
  logic dsub_q;
  logic ooff_q;
  logic gnd_off_q;
  logic [11:0] byp_data_q;
  logic [11:0] ofs_meas_q;
  logic [11:0] raw_q;
  logic [15:0] dac_q;
  logic [11:0] res_q [darb_pkg::NUM_CHAN];
  logic [darb_pkg::NUM_CHAN-1:0] flag_q;
  logic [11:0] mux_res_q;
  logic [1:0] evt_q;
  logic [1:0] mask_q;
  logic [15:0] rdata_q;
  logic [11:0] ofs_use;
  logic [12:0] diff;
  logic [11:0] corr;
  logic [11:0] eff;
  logic dsub_eff;
  logic out_of_win;
  logic [1:0] evt_set;
  logic [15:0] byp_rd;
  logic [15:0] flags_rd;
  logic [15:0] rd_d;
  logic start_q;

  // ----------------------------------------------------------------
  // sequencer with ground sampling between channels
  // ----------------------------------------------------------------

  // request accepted only while idle
  assign REQ_READY = (seq_q == darb_pkg::SEQ_IDLE);

  // state, ground window counter, captured channel and window;
  // limits are captured with the request, so a late change
  // of the window cannot touch a conversion in flight
  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      seq_q <= darb_pkg::SEQ_IDLE;
      gnd_cnt_q <= 8'h00;
      chan_q <= 3'h0;
      lim_lo_q <= darb_pkg::RST_DATA;
      lim_hi_q <= darb_pkg::RST_DATA;
    end
    else
    begin
      case (seq_q)
        darb_pkg::SEQ_IDLE:
        begin
          if (CHAN_REQ)
          begin
            chan_q <= CHAN_SEL;
            lim_lo_q <= LIMIT_LO;
            lim_hi_q <= LIMIT_HI;
            gnd_cnt_q <= 8'(darb_pkg::GND_SAMPLE_CYC - 1);
            if (gnd_off_q)
              seq_q <= darb_pkg::SEQ_CONV;
            else
              seq_q <= darb_pkg::SEQ_GND;
          end
        end
        darb_pkg::SEQ_GND:
        begin
          if (gnd_cnt_q == 8'h00)
            seq_q <= darb_pkg::SEQ_CONV;
          else
            gnd_cnt_q <= gnd_cnt_q - 8'h01;
        end
        darb_pkg::SEQ_CONV:
        begin
          if (SAR_DONE)
            seq_q <= darb_pkg::SEQ_IDLE;
        end
        default:
          seq_q <= darb_pkg::SEQ_IDLE;
      endcase
    end
  end

  // capacitor tied to ground during the ground window
  assign GND_SAMPLE = (seq_q == darb_pkg::SEQ_GND);

  // ----------------------------------------------------------------
  // conversion start towards the converter core
  // ----------------------------------------------------------------

  // start pulse on entry to conversion; registered so the core
  // never sees a glitch from the state decode
  always_ff @(posedge CLOCK)
  begin
    if (RST)
      start_q <= 1'b0;
    else
      start_q <= (seq_q != darb_pkg::SEQ_CONV) &&
                 (((seq_q == darb_pkg::SEQ_IDLE) && CHAN_REQ && gnd_off_q) ||
                  ((seq_q == darb_pkg::SEQ_GND) && (gnd_cnt_q == 8'h00)));
  end
  assign SAR_START = start_q;
  assign SAR_CHAN = chan_q;

  // ----------------------------------------------------------------
  // offset selection, correction and substitution
  // ----------------------------------------------------------------

  // override wins over substitution
  assign dsub_eff = dsub_q & ~ooff_q;

  // offset source: bypass data or measured value
  assign ofs_use = ooff_q ? byp_data_q : ofs_meas_q;

  // signed subtraction, clamped to the code range;
  // a wrap here would turn a small input into a full-scale code
  // and trip the wrong limit
  always_comb
  begin
    diff = {1'b0, SAR_RAW} - {ofs_use[11], ofs_use};
    if (ofs_use[11] && diff[12])
      corr = darb_pkg::DATA_MAX;
    else if (!ofs_use[11] && diff[12])
      corr = darb_pkg::RST_DATA;
    else
      corr = diff[11:0];
    eff = dsub_eff ? byp_data_q : corr;
    out_of_win = (eff < lim_lo_q) || (eff > lim_hi_q);
  end

  // ----------------------------------------------------------------
  // bypass control register
  // ----------------------------------------------------------------

  // software-written controls and data;
  // both enables written together store substitution off
  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      dsub_q <= 1'b0;
      ooff_q <= 1'b0;
      gnd_off_q <= 1'b0;
      byp_data_q <= darb_pkg::RST_DATA;
    end
    else if (WR && (ADDR == darb_pkg::OFS_CONVERSION_OVERRIDE))
    begin
      dsub_q <= WDATA[darb_pkg::BIT_DATA_SUBSTITUTE_ON] &
                ~WDATA[darb_pkg::BIT_OFFSET_OVERRIDE_ON];
      ooff_q <= WDATA[darb_pkg::BIT_OFFSET_OVERRIDE_ON];
      gnd_off_q <= WDATA[darb_pkg::BIT_GROUND_SAMPLE_OFF];
      byp_data_q <= WDATA[11:0];
    end
  end

  // ----------------------------------------------------------------
  // measured offset, raw data and output code capture
  // ----------------------------------------------------------------

  // measured offset untouched by bypass settings;
  // override only swaps the offset used, never this copy
  always_ff @(posedge CLOCK)
  begin
    if (RST)
      ofs_meas_q <= darb_pkg::RST_DATA;
    else if (OFS_VALID)
      ofs_meas_q <= OFS_MEAS;
  end

  // raw code of every conversion;
  // a stray done strobe outside conversion is ignored
  always_ff @(posedge CLOCK)
  begin
    if (RST)
      raw_q <= darb_pkg::RST_DATA;
    else if (SAR_DONE && (seq_q == darb_pkg::SEQ_CONV))
      raw_q <= SAR_RAW;
  end

  // code applied to the output stage;
  // sampled every cycle, read back one cycle late
  always_ff @(posedge CLOCK)
  begin
    if (RST)
      dac_q <= darb_pkg::RST_REG;
    else
      dac_q <= DAC_CODE;
  end

  // ----------------------------------------------------------------
  // per-channel results and limit flags
  // ----------------------------------------------------------------
  for (genvar c = 0; c < darb_pkg::NUM_CHAN; c++)
  begin : g_chan
    // result and pass/fail of one channel;
    // flags follow the latest conversion of the channel, not sticky
    always_ff @(posedge CLOCK)
    begin
      if (RST)
      begin
        res_q[c] <= darb_pkg::RST_DATA;
        flag_q[c] <= 1'b0;
      end
      else if (SAR_DONE && (seq_q == darb_pkg::SEQ_CONV) && (chan_q == 3'(c)))
      begin
        res_q[c] <= eff;
        flag_q[c] <= out_of_win;
      end
    end
  end

  // last self-check conversion, any mux input
  always_ff @(posedge CLOCK)
  begin
    if (RST)
      mux_res_q <= darb_pkg::RST_DATA;
    else if (SAR_DONE && (seq_q == darb_pkg::SEQ_CONV) &&
             (chan_q >= darb_pkg::CH_SELF_CHECK_FIRST))
      mux_res_q <= eff;
  end

  // ----------------------------------------------------------------
  // events and interrupt
  // ----------------------------------------------------------------

  // conversion done and limit failure events
  always_comb
  begin
    evt_set = darb_pkg::RST_EVT;
    if (SAR_DONE && (seq_q == darb_pkg::SEQ_CONV))
    begin
      evt_set[darb_pkg::EVT_CONV_DONE] = 1'b1;
      evt_set[darb_pkg::EVT_LIMIT_FAIL] = out_of_win;
    end
  end

  // sticky status, write one to clear, set wins;
  // an event in the clearing cycle survives, so none is lost
  always_ff @(posedge CLOCK)
  begin
    if (RST)
      evt_q <= darb_pkg::RST_EVT;
    else if (WR && (ADDR == darb_pkg::OFS_EVENT_STATUS))
      evt_q <= (evt_q & ~WDATA[darb_pkg::EVT_W-1:0]) | evt_set;
    else
      evt_q <= evt_q | evt_set;
  end

  // interrupt mask
  always_ff @(posedge CLOCK)
  begin
    if (RST)
      mask_q <= darb_pkg::RST_EVT;
    else if (WR && (ADDR == darb_pkg::OFS_EVENT_MASK))
      mask_q <= WDATA[darb_pkg::EVT_W-1:0];
  end

  // ----------------------------------------------------------------
  // interrupt output
  // ----------------------------------------------------------------

  // level request while any unmasked status bit is set
  assign IRQ = |(evt_q & mask_q);

  // ----------------------------------------------------------------
  // register read
  // ----------------------------------------------------------------

  // readback views of packed fields
  always_comb
  begin
    byp_rd = darb_pkg::RST_REG;
    byp_rd[darb_pkg::BIT_DATA_SUBSTITUTE_ON] = dsub_eff;
    byp_rd[darb_pkg::BIT_OFFSET_OVERRIDE_ON] = ooff_q;
    byp_rd[darb_pkg::BIT_GROUND_SAMPLE_OFF] = gnd_off_q;
    byp_rd[11:0] = byp_data_q;
    flags_rd = darb_pkg::RST_REG;
    flags_rd[darb_pkg::FLAG_FIRST_BIT +: darb_pkg::NUM_CHAN] = flag_q;
  end

  // address decode, unmapped reads zero
  always_comb
  begin
    case (ADDR)
      darb_pkg::OFS_LIMIT_FAIL_FLAGS: rd_d = flags_rd;
      darb_pkg::OFS_INPUT_ZERO_RESULT: rd_d = {4'h0, res_q[darb_pkg::CH_INPUT_ZERO]};
      darb_pkg::OFS_INPUT_ONE_RESULT: rd_d = {4'h0, res_q[darb_pkg::CH_INPUT_ONE]};
      darb_pkg::OFS_DIE_TEMP_RESULT: rd_d = {4'h0, res_q[darb_pkg::CH_DIE_TEMP]};
      darb_pkg::OFS_SELF_CHECK_MUX_RESULT: rd_d = {4'h0, mux_res_q};
      darb_pkg::OFS_COMPARATOR_OFFSET: rd_d = {4'h0, ofs_meas_q};
      darb_pkg::OFS_APPLIED_OUTPUT_CODE: rd_d = dac_q;
      darb_pkg::OFS_RAW_CONVERSION_DATA: rd_d = {4'h0, raw_q};
      darb_pkg::OFS_CONVERSION_OVERRIDE: rd_d = byp_rd;
      darb_pkg::OFS_EVENT_STATUS: rd_d = {14'h0000, evt_q};
      darb_pkg::OFS_EVENT_MASK: rd_d = {14'h0000, mask_q};
      default: rd_d = darb_pkg::RST_REG;
    endcase
  end

  // ----------------------------------------------------------------
  // read data register
  // ----------------------------------------------------------------

  // read data valid the cycle after the strobe only;
  // zero otherwise, so a stale word is never taken for an answer
  always_ff @(posedge CLOCK)
  begin
    if (RST)
      rdata_q <= darb_pkg::RST_REG;
    else if (RD)
      rdata_q <= rd_d;
    else
      rdata_q <= darb_pkg::RST_REG;
  end

  assign RDATA = rdata_q;

endmodule

// [darb_top_properties.sv]
// darb_top_properties: port-level checks of the converter result block
// assumes it is bound to darb_top, one clock, synchronous active-high reset
module darb_top_properties (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic [7:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [15:0] RDATA,
  input wire logic CHAN_REQ,
  input wire logic REQ_READY,
  input wire logic GND_SAMPLE,
  input wire logic SAR_START,
  input wire logic SAR_DONE,
  input wire logic [11:0] SAR_RAW,
  input wire logic OFS_VALID,
  input wire logic [11:0] OFS_MEAS,
  input wire logic [15:0] DAC_CODE
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] byp_q;
  logic [11:0] ofs_q;
  logic [11:0] raw_q;
  // ----------------------------------------------------------------
  // shadow state
  // ----------------------------------------------------------------
  // shadow of bypass register, measured offset and raw code
  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      byp_q <= 16'h0000;
      ofs_q <= 12'h000;
      raw_q <= 12'h000;
    end
    else
    begin
      if (WR && ADDR == 8'h2E)
      begin
        byp_q <= {WDATA[15] & ~WDATA[14], WDATA[14:13], 1'b0, WDATA[11:0]};
      end
      if (OFS_VALID)
      begin
        ofs_q <= OFS_MEAS;
      end
      if (SAR_DONE && !REQ_READY && !GND_SAMPLE)
      begin
        raw_q <= SAR_RAW;
      end
    end
  end
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  hi_zero_a: assert property (
    $past(RD) && $past(ADDR) inside {8'h24, 8'h25, 8'h26, 8'h27, 8'h28, 8'h2D} |-> RDATA[15:12] == 4'h0)
    else $error("result upper bits not zero");
  flag_rsvd_a: assert property (
    $past(RD) && $past(ADDR) == 8'h23 |-> RDATA[15:9] == 7'h00 && !RDATA[0])
    else $error("reserved flag bits set");
  ofs_report_a: assert property (
    $past(RD) && $past(ADDR) == 8'h28 |-> RDATA == {4'h0, $past(ofs_q)})
    else $error("offset register not the measured value");
  raw_report_a: assert property (
    $past(RD) && $past(ADDR) == 8'h2D |-> RDATA == {4'h0, $past(raw_q)})
    else $error("raw data register wrong");
  byp_readback_a: assert property (
    $past(RD) && $past(ADDR) == 8'h2E |-> RDATA == $past(byp_q))
    else $error("bypass register readback wrong");
  dac_readback_a: assert property (
    $past(RD) && $past(ADDR) == 8'h2C && $past(DAC_CODE, 2) == $past(DAC_CODE)
    && $past(DAC_CODE, 3) == $past(DAC_CODE) |-> RDATA == $past(DAC_CODE))
    else $error("output code readback wrong");
  gnd_window_a: assert property (
    CHAN_REQ && REQ_READY && !byp_q[13] |=> GND_SAMPLE [*8] ##1 GND_SAMPLE [*2] ##1 (SAR_START && !GND_SAMPLE))
    else $error("ground window not ten cycles");
  gnd_skip_a: assert property (
    CHAN_REQ && REQ_READY && byp_q[13] |=> SAR_START && !GND_SAMPLE)
    else $error("ground sample not skipped");
  start_pulse_a: assert property (
    SAR_START |=> !SAR_START && !REQ_READY)
    else $error("start not a single pulse while busy");
  done_release_a: assert property (
    SAR_DONE && !REQ_READY && !GND_SAMPLE |=> REQ_READY)
    else $error("sequencer not idle after done");
  cover property (CHAN_REQ && REQ_READY && !byp_q[13]);
  cover property (CHAN_REQ && REQ_READY && byp_q[13]);
  cover property ($past(RD) && $past(ADDR) == 8'h2E);
endmodule

bind darb_top darb_top_properties i_darb_top_properties (.CLOCK(CLOCK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA),
  .WR(WR), .RD(RD), .RDATA(RDATA), .CHAN_REQ(CHAN_REQ), .REQ_READY(REQ_READY), .GND_SAMPLE(GND_SAMPLE),
  .SAR_START(SAR_START), .SAR_DONE(SAR_DONE), .SAR_RAW(SAR_RAW), .OFS_VALID(OFS_VALID), .OFS_MEAS(OFS_MEAS),
  .DAC_CODE(DAC_CODE));

// [tb_darb_top.sv]
// tb_darb_top: table-driven bench for the converter result block
// assumes darb_top with a 4 ns clock and the checker bound beside it
module tb_darb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic [2:0] ch;
    logic [11:0] raw;
    logic [15:0] byp;
    logic [11:0] lo;
    logic [11:0] hi;
    logic [11:0] res;
    logic fl;
  } darb_row_t;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic [15:0] rdata;
  logic chan_req = 1'b0;
  logic [2:0] chan_sel = 3'h0;
  logic [11:0] limit_lo = 12'h000;
  logic [11:0] limit_hi = 12'hFFF;
  logic req_ready, gnd_sample, sar_start, irq;
  logic [2:0] sar_chan;
  logic sar_done = 1'b0;
  logic [11:0] sar_raw = 12'h000;
  logic ofs_valid = 1'b0;
  logic [11:0] ofs_meas = 12'h000;
  logic [15:0] dac_code = 16'hA5C3;
  logic [15:0] ef = 16'h0000;
  int err_total = 0;
  int compares = 0;
  darb_row_t rows [8];
  darb_row_t r;
  logic [7:0] ra;
  logic [7:0] zero_regs [8] = '{8'h23, 8'h24, 8'h25, 8'h26, 8'h27, 8'h28, 8'h2D, 8'h2E};
  // clock
  always #2 clock = ~clock;
  darb_top i_darb_top (.CLOCK(clock), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr_stb), .RD(rd_stb),
    .RDATA(rdata), .CHAN_REQ(chan_req), .CHAN_SEL(chan_sel), .LIMIT_LO(limit_lo), .LIMIT_HI(limit_hi),
    .REQ_READY(req_ready), .GND_SAMPLE(gnd_sample), .SAR_START(sar_start), .SAR_CHAN(sar_chan),
    .SAR_DONE(sar_done), .SAR_RAW(sar_raw), .OFS_VALID(ofs_valid), .OFS_MEAS(ofs_meas), .DAC_CODE(dac_code),
    .IRQ(irq));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task end_sim;
    $display("mismatches=%0d compares=%0d", err_total, compares);
    if (err_total == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task bus_wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clock);
    wr_stb <= 1'b0;
  endtask
  task bus_rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge clock);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clock);
    rd_stb <= 1'b0;
    #1;
    chk(rdata, e);
  endtask
  // one conversion; dup keeps the request up while busy, where it is refused
  task conv(input darb_row_t c, input logic dup);
    int n;
    int g;
    n = 0;
    g = 0;
    @(posedge clock);
    chan_req <= 1'b1;
    chan_sel <= c.ch;
    limit_lo <= c.lo;
    limit_hi <= c.hi;
    @(posedge clock);
    chan_req <= dup;
    chan_sel <= ~c.ch;
    @(negedge clock);
    while (sar_start !== 1'b1 && n < 40)
    begin
      g += int'(gnd_sample === 1'b1);
      n++;
      @(negedge clock);
    end
    chk(16'(g), c.byp[13] ? 16'h0000 : 16'h000A);
    chk({13'h0000, sar_chan}, {13'h0000, c.ch});
    @(posedge clock);
    chan_req <= 1'b0;
    sar_done <= 1'b1;
    sar_raw <= c.raw;
    @(posedge clock);
    sar_done <= 1'b0;
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    rows = '{'{3'h0, 12'h123, 16'h0000, 12'h000, 12'hFFF, 12'h113, 1'b0},
             '{3'h1, 12'h005, 16'h0000, 12'h000, 12'hFFF, 12'h000, 1'b0},
             '{3'h2, 12'h800, 16'h4FFE, 12'h000, 12'h801, 12'h802, 1'b1},
             '{3'h3, 12'h400, 16'h8ABC, 12'h000, 12'hFFF, 12'hABC, 1'b0},
             '{3'h7, 12'h200, 16'hC055, 12'h1AC, 12'hFFF, 12'h1AB, 1'b1}, // both enables, against
             '{3'h4, 12'h0FF, 16'h2000, 12'h000, 12'hFFF, 12'h0EF, 1'b0},
             '{3'h5, 12'h300, 16'h0000, 12'h2F1, 12'hFFF, 12'h2F0, 1'b1},
             '{3'h6, 12'h050, 16'h2000, 12'h041, 12'hFFF, 12'h040, 1'b1}};
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    ofs_valid <= 1'b1;
    ofs_meas <= 12'h010;
    @(posedge clock);
    ofs_valid <= 1'b0;
    bus_wr(8'h31, 16'h0003);
    foreach (rows[i])
    begin
      r = rows[i];
      bus_wr(8'h2E, r.byp);
      conv(r, i[0]);
      ef[r.ch + 1] = r.fl;
      ra = (r.ch < 3'h3) ? 8'h24 + 8'(r.ch) : 8'h27;
      bus_rd(ra, {4'h0, r.res});
      bus_rd(8'h2D, {4'h0, r.raw});
      bus_rd(8'h23, ef);
      bus_rd(8'h2E, {r.byp[15] & ~r.byp[14], r.byp[14:13], 1'b0, r.byp[11:0]});
      bus_rd(8'h28, 16'h0010);
    end
    // interrupt raised, cleared, then masked
    chk(16'(irq), 16'h0001);
    bus_wr(8'h30, 16'h0003);
    #1;
    chk(16'(irq), 16'h0000);
    bus_wr(8'h31, 16'h0002);
    bus_wr(8'h2E, 16'h0000);
    conv(rows[0], 1'b0);
    repeat (2) @(negedge clock);
    chk(16'(irq), 16'h0000);
    bus_rd(8'h30, 16'h0001);
    conv(rows[6], 1'b0);
    repeat (2) @(negedge clock);
    chk(16'(irq), 16'h0001);
    // unmapped read, write to a read-only result
    bus_rd(8'h20, 16'h0000);
    bus_wr(8'h24, 16'hFFFF);
    bus_rd(8'h24, 16'h0113);
    bus_rd(8'h2C, dac_code);
    // second reset clears the result, flag, offset, raw and bypass registers
    @(posedge clock);
    rst <= 1'b1;
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    foreach (zero_regs[i])
      bus_rd(zero_regs[i], 16'h0000);
    chk(16'(req_ready), 16'h0001);
    end_sim();
  end
  // watchdog
  initial
  begin
    repeat (6000) @(posedge clock);
    err_total++;
    end_sim();
  end
endmodule
